// File: rtl/ltwr_defs.svh
`ifndef LTWR_DEFS_SVH
`define LTWR_DEFS_SVH

// Trigger function geometry.
`define NUM_CHAN      4
`define NUM_COL       2
`define NUM_TERM      8
`define TERM_W        3
`define TERMS_W       24

// Positions inside the synchronised pin vector.
`define PIN_W         11
`define PIN_CHAN_LSB  0
`define PIN_EXTCLK    4
`define PIN_EXTRST    5
`define PIN_SWEEP     6
`define PIN_PROBE_LSB 7

// Timing: the chop rate is derived from the system clock rate.
`define CLK_HZ        200000000
`define CHOP_HZ       1000000
`define CHOP_CYCLES   (`CLK_HZ / `CHOP_HZ)

// Reset values.
`define RST_DISP_CHAN 2'h0

`endif

// File: rtl/ltwr_pkg.sv
`include "ltwr_defs.svh"

package ltwr_pkg;

	typedef enum logic [`TERM_W-1:0]
	{
		TERM_X,
		TERM_HI,
		TERM_LO,
		TERM_RISE,
		TERM_FALL
	} term_e;

	typedef logic [`TERM_W-1:0] term_t;

endpackage

// File: rtl/fn_link_if.sv
`timescale 1ns/1ps
`include "ltwr_defs.svh"

interface fn_link_if;
	logic [`TERMS_W-1:0]  terms;
	logic [`NUM_CHAN-1:0] lvl;
	logic [`NUM_CHAN-1:0] prv;
	logic                 hit;
	logic                 has_edge;
	logic                 programmed;

	modport host
	(
		output terms,
		output lvl,
		output prv,
		input  hit,
		input  has_edge,
		input  programmed
	);

	modport eval
	(
		input  terms,
		input  lvl,
		input  prv,
		output hit,
		output has_edge,
		output programmed
	);
endinterface

// File: rtl/fn_word_eval.sv
`timescale 1ns/1ps
`include "ltwr_defs.svh"

module fn_word_eval
	import ltwr_pkg::*;
(
	input  wire logic clk_i,        // System clock.
	input  wire logic rst_i,        // Asynchronous reset, active high.
	fn_link_if.eval   link          // Terms in, match result out.
);

	logic [`NUM_TERM-1:0] match;
	logic [`NUM_TERM-1:0] active;
	logic [`NUM_TERM-1:0] edgy;
	logic [`NUM_COL-1:0]  col_true;
	logic                 hit;

	for (genvar s = 0; s < `NUM_TERM; s++)
	begin : g_term
		localparam int K = s % `NUM_CHAN;
		wire term_t code = link.terms[s*`TERM_W +: `TERM_W];
		wire        lv   = link.lvl[K];
		wire        pv   = link.prv[K];
		// Codes outside the defined set behave as don't care.
		assign match[s]  = (code == TERM_HI)   ? lv :
		                   (code == TERM_LO)   ? !lv :
		                   (code == TERM_RISE) ? (lv && !pv) :
		                   (code == TERM_FALL) ? (!lv && pv) : 1'b1;
		assign active[s] = (code == TERM_HI) || (code == TERM_LO) ||
		                   (code == TERM_RISE) || (code == TERM_FALL);
		assign edgy[s]   = (code == TERM_RISE) || (code == TERM_FALL);
	end

	for (genvar c = 0; c < `NUM_COL; c++)
	begin : g_col
		// A column with every term don't care is inactive, not always true.
		assign col_true[c] = (&match[c*`NUM_CHAN +: `NUM_CHAN]) &&
		                     (|active[c*`NUM_CHAN +: `NUM_CHAN]);
	end

	assign link.has_edge   = |edgy;
	assign link.programmed = |active;
	assign link.hit        = hit;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			hit <= 1'b0;
		else
			hit <= |col_true;
	end

	AST_EMPTY_NEVER_HITS: assert property (@(posedge clk_i) disable iff (rst_i)
		!link.programmed |=> !hit)
		else $error("Empty function produced a hit.");

endmodule

// File: rtl/logic_trigger_word_recognizer.sv
`timescale 1ns/1ps
`include "ltwr_defs.svh"

module logic_trigger_word_recognizer
	import ltwr_pkg::*;
#(
	parameter int CHOP_DIV = `CHOP_CYCLES        // Clock cycles per chop step.
)
(
	input  wire logic                 clk_i,              // System clock, 200 MHz.
	input  wire logic                 rst_i,              // Asynchronous reset, high.
	input  wire logic [`NUM_CHAN-1:0] chan_thr_i,         // Thresholded channel pins.
	input  wire logic                 ext_clk_i,          // External clock pin.
	input  wire logic                 ext_reset_i,        // External reset pin, high.
	input  wire logic                 sweep_done_i,       // Time-base sweep end pin.
	input  wire logic [`NUM_CHAN-1:0] probe_sense_i,      // 10X probe sensed pins.
	input  wire logic                 func_sel_b_i,       // Selected function: 1 = B.
	input  wire logic                 prog_we_i,          // Write one term, pulse.
	input  wire logic [2:0]           prog_slot_i,        // Column*4 + channel.
	input  wire logic [`TERM_W-1:0]   prog_term_i,        // Term code to write.
	input  wire logic                 clear_i,            // Clear selected, pulse.
	input  wire logic                 nested_mode_i,      // Nested A then B mode.
	input  wire logic                 ext_qual_req_i,     // Request external qualify.
	input  wire logic                 ext_slope_rise_i,   // Qualify on rising edge.
	input  wire logic                 replica_req_i,      // Request replica trace.
	input  wire logic [`NUM_CHAN-1:0] display_en_i,       // Per-channel display on.
	input  wire logic [`NUM_CHAN-1:0] input_ground_i,     // Per-channel ground.
	input  wire logic                 alt_mode_i,         // 1 = alternate, 0 = chop.
	input  wire logic [`NUM_CHAN-1:0] family_ttl_i,       // 1 = TTL, 0 = ECL.
	input  wire logic [`NUM_CHAN-1:0] hiz_sel_i,          // 1 = one megohm.
	output logic                      trig_out_o,         // Trigger to time base.
	output logic                      replica_o,          // Replica trace level.
	output logic                      replica_on_o,       // Replica trace shown.
	output logic                      ext_qual_o,         // External qualify active.
	output logic                      armed_o,            // Nested armed state.
	output logic                      msg_edge_conflict_o,// Edge/ext clock refusal.
	output logic                      msg_no_func_a_o,    // Function A missing.
	output logic [1:0]                disp_chan_o,        // Channel being displayed.
	output logic                      disp_on_o,          // Any channel displayed.
	output logic [`NUM_CHAN-1:0]      amp_ground_o,       // Amplifier input grounded.
	output logic [`NUM_CHAN-1:0]      conn_path_o,        // Connector path closed.
	output logic [`NUM_CHAN-1:0]      term_50_o,          // 50 ohm termination on.
	output logic [`NUM_CHAN-1:0]      family_ttl_o,       // TTL thresholds in use.
	output logic [`NUM_CHAN-1:0]      readout_x10_o       // Readout scaled by ten.
);

	localparam int CW = (CHOP_DIV > 2) ? $clog2(CHOP_DIV) : 1;

	if (CHOP_DIV < 2)
	begin : g_bad_div
		$error("CHOP_DIV must be at least 2.");
	end

	fn_link_if link_a ();
	fn_link_if link_b ();

	fn_word_eval u_eval_a
	(
		.clk_i (clk_i),
		.rst_i (rst_i),
		.link  (link_a.eval)
	);

	fn_word_eval u_eval_b
	(
		.clk_i (clk_i),
		.rst_i (rst_i),
		.link  (link_b.eval)
	);

	logic [`PIN_W-1:0]    pin_s1;
	logic [`PIN_W-1:0]    pin_s2;
	logic [`NUM_CHAN-1:0] chan_prv;
	logic                 ext_clk_d;
	logic                 sweep_d;
	logic                 qual_strobe;
	logic                 hit_a_d;
	logic                 hit_b_d;
	logic                 nested_q;
	logic                 req_d;
	logic                 armed;
	logic [CW-1:0]        chop_cnt;
	logic [1:0]           disp_chan;

	wire [`PIN_W-1:0] pin_raw = {probe_sense_i, sweep_done_i, ext_reset_i, ext_clk_i,
	                             chan_thr_i};
	wire [`NUM_CHAN-1:0] chan_s  = pin_s2[`PIN_CHAN_LSB +: `NUM_CHAN];
	wire                 ext_lvl = pin_s2[`PIN_EXTCLK];
	wire                 ext_rst = pin_s2[`PIN_EXTRST];
	wire                 sweep_s = pin_s2[`PIN_SWEEP];
	wire [`NUM_CHAN-1:0] probe_s = pin_s2[`PIN_PROBE_LSB +: `NUM_CHAN];

	// Grounding opens the connector path, so the comparator sees a low input.
	wire [`NUM_CHAN-1:0] trig_lvl = chan_s & ~input_ground_i;

	assign link_a.lvl = trig_lvl;
	assign link_a.prv = chan_prv;
	assign link_b.lvl = trig_lvl;
	assign link_b.prv = chan_prv;

	// Term programming and clearing touch only the selected function.
	wire is_edge_term = (prog_term_i == TERM_RISE) || (prog_term_i == TERM_FALL);
	wire edge_refused = prog_we_i && is_edge_term && ext_qual_o;
	wire prog_ok      = prog_we_i && !edge_refused;
	wire wr_a         = prog_ok && !func_sel_b_i;
	wire wr_b         = prog_ok && func_sel_b_i;
	wire clr_a        = clear_i && !func_sel_b_i;
	wire clr_b        = clear_i && func_sel_b_i;

	for (genvar s = 0; s < `NUM_TERM; s++)
	begin : g_slot
		term_t ta;
		term_t tb;
		wire   here = (prog_slot_i == 3'(s));

		assign link_a.terms[s*`TERM_W +: `TERM_W] = ta;
		assign link_b.terms[s*`TERM_W +: `TERM_W] = tb;

		always_ff @(posedge clk_i or posedge rst_i)
		begin
			if (rst_i)
			begin
				ta <= TERM_X;
				tb <= TERM_X;
			end
			else
			begin
				if (clr_a)
					ta <= TERM_X;
				else if (wr_a && here)
					ta <= prog_term_i;
				if (clr_b)
					tb <= TERM_X;
				else if (wr_b && here)
					tb <= prog_term_i;
			end
		end
	end

	// External qualify is only entered on a fresh request with no edge terms.
	wire any_edge      = link_a.has_edge || link_b.has_edge;
	wire qual_refused  = ext_qual_req_i && !req_d && any_edge && !ext_qual_o;
	wire next_ext_qual = ext_qual_req_i && (ext_qual_o || (!req_d && !any_edge));
	wire next_msg_edge = edge_refused || qual_refused;

	wire next_msg_no_a = (nested_mode_i && !nested_q && !link_a.programmed) ||
	                     (nested_q && clr_a);

	// The strobe is delayed one cycle to line up with the registered hits.
	wire ext_edge = ext_slope_rise_i ? (ext_lvl && !ext_clk_d) :
	                                   (!ext_lvl && ext_clk_d);

	wire hit_a = link_a.hit && !ext_rst;
	wire hit_b = link_b.hit && !ext_rst;
	wire evt_a = ext_qual_o ? (hit_a && qual_strobe) : (hit_a && !hit_a_d);
	wire evt_b = ext_qual_o ? (hit_b && qual_strobe) : (hit_b && !hit_b_d);
	wire sel_hit = func_sel_b_i ? hit_b : hit_a;
	wire single_trig = ext_qual_o ? (sel_hit && qual_strobe) : sel_hit;
	wire fire = nested_q && armed && evt_b;
	wire next_trig = nested_q ? fire : single_trig;

	wire mode_change = nested_mode_i != nested_q;
	// Further A events while armed change nothing; the same state is held.
	wire next_armed = (!nested_q || mode_change || ext_rst) ? 1'b0 :
	                  fire  ? 1'b0 :
	                  evt_a ? 1'b1 : armed;

	wire next_replica    = ext_qual_o ? ext_lvl : next_trig;
	wire next_replica_on = replica_req_i || (display_en_i == '0);

	// Display switching among enabled channels.
	function automatic logic [1:0] next_enabled(input logic [1:0] cur,
	                                            input logic [`NUM_CHAN-1:0] en);
		logic [1:0] pick;
		logic [1:0] cand;
		pick = cur;
		for (int i = `NUM_CHAN - 1; i >= 1; i--)
		begin
			cand = 2'(cur + 2'(i));
			if (en[cand])
				pick = cand;
		end
		return pick;
	endfunction

	wire           sweep_evt = sweep_s && !sweep_d;
	wire           chop_tick = chop_cnt == CW'(CHOP_DIV - 1);
	wire           advance   = alt_mode_i ? sweep_evt : chop_tick;
	wire [CW-1:0]  next_chop = chop_tick ? '0 : CW'(chop_cnt + 1'b1);
	wire [1:0]     next_disp = advance ? next_enabled(disp_chan, display_en_i) : disp_chan;

	assign disp_chan_o = disp_chan;
	assign armed_o     = armed;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pin_s1 <= '0;
			pin_s2 <= '0;
		end
		else
		begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			chan_prv    <= '0;
			ext_clk_d   <= 1'b0;
			sweep_d     <= 1'b0;
			qual_strobe <= 1'b0;
			hit_a_d     <= 1'b0;
			hit_b_d     <= 1'b0;
			nested_q    <= 1'b0;
			req_d       <= 1'b0;
		end
		else
		begin
			chan_prv    <= trig_lvl;
			ext_clk_d   <= ext_lvl;
			sweep_d     <= sweep_s;
			qual_strobe <= ext_edge;
			hit_a_d     <= hit_a;
			hit_b_d     <= hit_b;
			nested_q    <= nested_mode_i;
			req_d       <= ext_qual_req_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			armed               <= 1'b0;
			trig_out_o          <= 1'b0;
			replica_o           <= 1'b0;
			replica_on_o        <= 1'b0;
			ext_qual_o          <= 1'b0;
			msg_edge_conflict_o <= 1'b0;
			msg_no_func_a_o     <= 1'b0;
		end
		else
		begin
			armed               <= next_armed;
			trig_out_o          <= next_trig;
			replica_o           <= next_replica;
			replica_on_o        <= next_replica_on;
			ext_qual_o          <= next_ext_qual;
			msg_edge_conflict_o <= next_msg_edge;
			msg_no_func_a_o     <= next_msg_no_a;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			chop_cnt  <= '0;
			disp_chan <= `RST_DISP_CHAN;
			disp_on_o <= 1'b0;
		end
		else
		begin
			chop_cnt  <= next_chop;
			disp_chan <= next_disp;
			disp_on_o <= |display_en_i;
		end
	end

	// Channel status: ground is independent of display, so the trace remains.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			amp_ground_o  <= '0;
			conn_path_o   <= '0;
			term_50_o     <= '0;
			family_ttl_o  <= '0;
			readout_x10_o <= '0;
		end
		else
		begin
			amp_ground_o  <= input_ground_i;
			conn_path_o   <= ~input_ground_i;
			term_50_o     <= ~hiz_sel_i;
			family_ttl_o  <= family_ttl_i;
			readout_x10_o <= probe_s;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_nested_unarmed;
		nested_q && !armed ##1 nested_q;
	endsequence

	AST_NO_B_WHILE_UNARMED: assert property (s_nested_unarmed |-> !trig_out_o)
		else $error("Nested trigger without arming.");

	AST_DISARM_AFTER_FIRE: assert property (nested_q && $past(nested_q) && trig_out_o
		|-> !armed)
		else $error("Still armed after nested trigger.");

	AST_REPLICA_FOLLOWS: assert property (!ext_qual_o |=> replica_o == trig_out_o)
		else $error("Replica differs from trigger output.");

	AST_REPLICA_EXTCLK: assert property (ext_qual_o |=> replica_o == $past(ext_lvl))
		else $error("Replica does not show external clock.");

	AST_REPLICA_FORCED: assert property (display_en_i == '0 |=> replica_on_o)
		else $error("Replica off with all displays off.");

	AST_EXT_RESET_BLOCKS: assert property (ext_rst |=> !trig_out_o && !armed)
		else $error("External reset did not block trigger.");

	AST_QUAL_ON_EDGE: assert property (ext_qual_o && $past(ext_qual_o) && trig_out_o
		|-> $past(qual_strobe))
		else $error("Qualified trigger away from clock edge.");

	AST_EDGE_REFUSED: assert property (prog_we_i && is_edge_term && ext_qual_o
		|=> msg_edge_conflict_o)
		else $error("Edge term under external qualify not flagged.");

	AST_NO_FUNC_A: assert property (nested_mode_i && !nested_q && !link_a.programmed
		|=> msg_no_func_a_o)
		else $error("Missing function A not flagged.");

	AST_OTHER_KEPT: assert property (clear_i && !func_sel_b_i
		|=> link_b.terms == $past(link_b.terms))
		else $error("Clearing A changed function B.");

endmodule

// File: tb/time_base_model.sv
`timescale 1ns/1ps
// A trigger that arrives while idle starts one sweep; the end of the sweep is
// shown as a short high level, and retriggers during a sweep do not restart it.
module time_base_model
#(
	parameter int SWEEP_LEN = 16    // Cycles per sweep.
)
(
	input  wire logic clk_i,        // System clock.
	input  wire logic rst_i,        // Reset, active high.
	input  wire logic trig_i,       // Trigger from the plug-in.
	output logic      sweep_done_o, // Sweep end level.
	output int        n_trig_o      // Trigger events seen.
);
	logic trig_q;
	int   left;

	always @(negedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			trig_q <= 1'b0;
			left <= 0;
			sweep_done_o <= 1'b0;
			n_trig_o <= 0;
		end
		else
		begin
			trig_q <= trig_i;
			sweep_done_o <= (left > 0 && left <= 3);
			if (trig_i && !trig_q)
				n_trig_o <= n_trig_o + 1;
			if (left > 0)
				left <= left - 1;
			else if (trig_i && !trig_q)
				left <= SWEEP_LEN + 3;
		end
	end
endmodule

// File: tb/logic_trigger_word_recognizer_tb.sv
`timescale 1ns/1ps
`include "ltwr_defs.svh"

module logic_trigger_word_recognizer_tb;
	import ltwr_pkg::*;
	localparam int SWEEP = 16;
	logic       clk_i, rst_i, ext_clk_i, ext_reset_i, sweep_done_i, func_sel_b_i, prog_we_i;
	logic       clear_i, nested_mode_i, ext_qual_req_i, ext_slope_rise_i, replica_req_i;
	logic       alt_mode_i, trig_out_o, replica_o, replica_on_o, ext_qual_o, armed_o;
	logic       msg_edge_conflict_o, msg_no_func_a_o, disp_on_o, got_e, got_a;
	logic [3:0] chan_thr_i, probe_sense_i, display_en_i, input_ground_i, family_ttl_i;
	logic [3:0] hiz_sel_i, amp_ground_o, conn_path_o, term_50_o, family_ttl_o, readout_x10_o;
	logic [2:0] prog_slot_i;
	logic [2:0] prog_term_i;
	logic [1:0] disp_chan_o, d;
	int         n_mismatch, compares, cyc, n_trig, n0;
	logic [3:0] cv [4] = '{4'h2, 4'h1, 4'h0, 4'h2};
	logic [3:0] ev [4] = '{4'h0, 4'h1, 4'h1, 4'h0};

	logic_trigger_word_recognizer #(.CHOP_DIV(4)) i_logic_trigger_word_recognizer
	(
		.clk_i, .rst_i, .chan_thr_i, .ext_clk_i, .ext_reset_i, .sweep_done_i,
		.probe_sense_i, .func_sel_b_i, .prog_we_i, .prog_slot_i, .prog_term_i, .clear_i,
		.nested_mode_i, .ext_qual_req_i, .ext_slope_rise_i, .replica_req_i, .display_en_i,
		.input_ground_i, .alt_mode_i, .family_ttl_i, .hiz_sel_i, .trig_out_o, .replica_o,
		.replica_on_o, .ext_qual_o, .armed_o, .msg_edge_conflict_o, .msg_no_func_a_o,
		.disp_chan_o, .disp_on_o, .amp_ground_o, .conn_path_o, .term_50_o, .family_ttl_o,
		.readout_x10_o
	);

	time_base_model #(.SWEEP_LEN(SWEEP)) i_time_base_model
	(
		.clk_i, .rst_i, .trig_i(trig_out_o), .sweep_done_o(sweep_done_i), .n_trig_o(n_trig)
	);

	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// One-cycle message pulses are caught here and cleared by the sequence.
	always @(posedge clk_i)
	begin
		cyc++;
		if (msg_edge_conflict_o === 1'b1)
			got_e = 1'b1;
		if (msg_no_func_a_o === 1'b1)
			got_a = 1'b1;
		if (cyc == 20000)
		begin
			n_mismatch++;
			results();
		end
	end

	task check(input string name, input logic [3:0] seen, input logic [3:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	task tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	task prog(input logic b, input logic [2:0] slot, input term_e t);
		func_sel_b_i = b;
		prog_slot_i = slot;
		prog_term_i = t;
		prog_we_i = 1'b1;
		tick(1);
		prog_we_i = 1'b0;
		tick(1);
	endtask

	task clr(input logic b);
		func_sel_b_i = b;
		clear_i = 1'b1;
		tick(1);
		clear_i = 1'b0;
		tick(1);
	endtask

	task pins(input logic [3:0] c);
		chan_thr_i = c;
		tick(6);
	endtask

	function logic [1:0] nxt(input logic [1:0] c, input logic [3:0] en);
		logic [1:0] k;
		k = c;
		for (int i = 0; i < 4; i++)
		begin
			k = k + 2'h1;
			if (en[k])
				return k;
		end
		return c;
	endfunction

	task results;
		if (n_mismatch == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		{ext_clk_i, ext_reset_i, func_sel_b_i, prog_we_i, clear_i, nested_mode_i} = 6'h00;
		{ext_qual_req_i, replica_req_i, got_e, got_a} = 4'h0;
		{ext_slope_rise_i, alt_mode_i, rst_i} = 3'h7;
		{chan_thr_i, probe_sense_i, input_ground_i} = 12'h000;
		prog_slot_i = 3'h0;
		prog_term_i = 3'h0;
		display_en_i = 4'hF;
		family_ttl_i = 4'h5;
		hiz_sel_i = 4'h3;
		probe_sense_i = 4'h9;
		tick(2);
		check("trig reset", trig_out_o, 4'h0);
		check("conn reset", conn_path_o, 4'h0);
		rst_i = 1'b0;
		tick(6);
		check("family", family_ttl_o, 4'h5);
		check("term50", term_50_o, 4'hC);
		check("x10", readout_x10_o, 4'h9);
		prog(1'b0, 3'h0, TERM_HI);
		prog(1'b0, 3'h5, TERM_LO);
		for (int i = 0; i < 4; i++)
		begin
			pins(cv[i]);
			check("trig word", trig_out_o, ev[i]);
			check("replica", replica_o, ev[i]);
		end
		pins(4'h3);
		ext_reset_i = 1'b1;
		tick(6);
		check("trig ext reset", trig_out_o, 4'h0);
		ext_reset_i = 1'b0;
		display_en_i = 4'h0;
		tick(6);
		check("trig no display", trig_out_o, 4'h1);
		check("replica forced", replica_on_o, 4'h1);
		check("disp off", disp_on_o, 4'h0);
		input_ground_i = 4'h1;
		tick(6);
		check("trig grounded", trig_out_o, 4'h0);
		check("amp ground", amp_ground_o, 4'h1);
		check("conn path", conn_path_o, 4'hE);
		input_ground_i = 4'h0;
		display_en_i = 4'hF;
		tick(6);
		check("replica off", replica_on_o, 4'h0);
		replica_req_i = 1'b1;
		tick(2);
		check("replica req", replica_on_o, 4'h1);
		replica_req_i = 1'b0;
		func_sel_b_i = 1'b1;
		tick(6);
		check("trig empty b", trig_out_o, 4'h0);
		prog(1'b1, 3'h2, TERM_HI);
		pins(4'h4);
		check("trig b", trig_out_o, 4'h1);
		clr(1'b1);
		tick(4);
		check("trig b cleared", trig_out_o, 4'h0);
		prog(1'b1, 3'h2, TERM_HI);
		func_sel_b_i = 1'b0;
		pins(4'h3);
		check("trig a kept", trig_out_o, 4'h1);
		clr(1'b0);
		prog(1'b0, 3'h0, TERM_HI);
		pins(4'h0);
		got_a = 1'b0;
		nested_mode_i = 1'b1;
		tick(SWEEP + 8);
		check("msg a present", got_a, 4'h0);
		n0 = n_trig;
		pins(4'h4);
		check("b unarmed", 4'(n_trig - n0), 4'h0);
		pins(4'h0);
		pins(4'h1);
		check("armed", armed_o, 4'h1);
		pins(4'h0);
		pins(4'h1);
		check("armed kept", armed_o, 4'h1);
		pins(4'h4);
		check("nested trig", 4'(n_trig - n0), 4'h1);
		check("disarmed", armed_o, 4'h0);
		pins(4'h0);
		pins(4'h4);
		check("no retrig", 4'(n_trig - n0), 4'h1);
		pins(4'h1);
		pins(4'h0);
		ext_reset_i = 1'b1;
		tick(6);
		check("reset disarms", armed_o, 4'h0);
		ext_reset_i = 1'b0;
		nested_mode_i = 1'b0;
		clr(1'b0);
		got_a = 1'b0;
		nested_mode_i = 1'b1;
		tick(4);
		check("msg no a", got_a, 4'h1);
		prog(1'b0, 3'h0, TERM_HI);
		got_a = 1'b0;
		clr(1'b0);
		check("msg clear a", got_a, 4'h1);
		nested_mode_i = 1'b0;
		prog(1'b0, 3'h0, TERM_RISE);
		got_e = 1'b0;
		ext_qual_req_i = 1'b1;
		tick(4);
		check("msg edge", got_e, 4'h1);
		check("qual refused", ext_qual_o, 4'h0);
		ext_qual_req_i = 1'b0;
		clr(1'b0);
		ext_qual_req_i = 1'b1;
		tick(4);
		check("qual on", ext_qual_o, 4'h1);
		got_e = 1'b0;
		prog(1'b0, 3'h0, TERM_FALL);
		tick(2);
		check("msg edge term", got_e, 4'h1);
		ext_clk_i = 1'b1;
		tick(6);
		check("replica clk hi", replica_o, 4'h1);
		ext_clk_i = 1'b0;
		tick(6);
		check("replica clk lo", replica_o, 4'h0);
		prog(1'b0, 3'h0, TERM_HI);
		pins(4'h1);
		tick(SWEEP + 8);
		n0 = n_trig;
		ext_clk_i = 1'b1;
		tick(6);
		check("qual trig", 4'(n_trig - n0), 4'h1);
		ext_slope_rise_i = 1'b0;
		tick(SWEEP + 8);
		ext_clk_i = 1'b0;
		tick(6);
		check("qual fall", 4'(n_trig - n0), 4'h2);
		pins(4'h0);
		tick(SWEEP + 8);
		ext_clk_i = 1'b1;
		tick(6);
		ext_clk_i = 1'b0;
		tick(6);
		check("qual false", 4'(n_trig - n0), 4'h2);
		ext_slope_rise_i = 1'b1;
		ext_qual_req_i = 1'b0;
		display_en_i = 4'hB;
		tick(SWEEP + 20);
		d = disp_chan_o;
		pins(4'h1);
		tick(SWEEP + 16);
		check("alt step", disp_chan_o, nxt(d, 4'hB));
		check("disp on", disp_on_o, 4'h1);
		alt_mode_i = 1'b0;
		d = disp_chan_o;
		tick(4);
		check("chop step", disp_chan_o, nxt(d, 4'hB));
		tick(4);
		check("chop again", disp_chan_o, nxt(nxt(d, 4'hB), 4'hB));
		results();
	end
endmodule
